// File: design/rwi_ctrl.sv
// Reset, watchdog and interrupt vectoring controller for an 8-bit core.
// Assumes the core gives one-cycle strobes for instruction end, return and data writes.
`timescale 1ns/100ps
`default_nettype none
module rwi_ctrl
  import rwi_pkg::*;
(
  input  wire logic         i_clock,
  input  wire logic         i_reset,
  input  wire logic         i_pin_reset_n,
  input  wire logic         i_nmi_req,
  input  wire logic         i_timer3_req,
  input  wire logic         i_port_a_req,
  input  wire logic         i_port_b_req,
  input  wire logic         i_timer2_req,
  input  wire logic         i_vsync_req,
  input  wire logic         i_i2c_req,
  input  wire logic         i_timer1_req,
  input  wire logic         i_ddc_req,
  input  wire logic         i_adc_req,
  input  wire logic         i_power_fail_input,
  input  wire rwi_core_ev_t i_core_ev,
  input  wire logic         i_data_wr,
  input  wire logic [7:0]   i_data_addr,
  input  wire logic [7:0]   i_data_wdata,
  output logic [7:0]        o_wd_rdata,
  output logic              o_core_reset,
  output logic              o_ports_input_pullup,
  output logic              o_stack_clear,
  output logic              o_pc_load,
  output logic [11:0]       o_pc_value,
  output logic              o_nmi_mode,
  output logic              o_irq_mode,
  output logic              o_enter_wait
);

  typedef struct packed {
    logic [NUM_MASKABLE-1:0] pend;
    logic                    nmi_pend;
    logic                    nmi_mode;
    logic                    irq_mode;
    logic                    gen;
    logic                    pc_load;
    logic [11:0]             pc_value;
    logic                    stack_clear;
    logic                    enter_wait;
    logic [7:0]              wd_rdata;
    logic                    core_reset;
    logic                    ports_input;
  } rwi_ctl_t;

  rwi_ctl_t c_q;
  rwi_ctl_t c_d;

  logic                    seq_reset;
  logic                    seq_ports;
  logic                    seq_load_vec;
  logic                    wd_expire;
  logic [7:0]              wd_rdata;
  logic [NUM_MASKABLE-1:0] req;
  logic [NUM_MASKABLE-1:0] grant;
  logic [NUM_MASKABLE-1:0] pend_now;
  logic                    wd_wr;

  rwi_reset_seq i_rwi_reset_seq (
    .i_clock       (i_clock),
    .i_reset       (i_reset),
    .i_pin_reset_n (i_pin_reset_n),
    .i_wd_reset    (wd_expire),
    .o_core_reset  (seq_reset),
    .o_ports_input (seq_ports),
    .o_load_vector (seq_load_vec)
  );

  assign wd_wr = i_data_wr && (i_data_addr == WD_ADDR) && !seq_reset;

  rwi_watchdog i_rwi_watchdog (
    .i_clock      (i_clock),
    .i_reset      (i_reset),
    .i_core_reset (seq_reset),
    .i_wr         (wd_wr),
    .i_wdata      (i_data_wdata),
    .o_rdata      (wd_rdata),
    .o_expire     (wd_expire)
  );

  // Sources sharing one vector are or-ed into one request
  assign req[0] = i_timer3_req || i_port_a_req || i_port_b_req;
  assign req[1] = i_timer2_req || i_vsync_req || i_i2c_req;
  assign req[2] = i_timer1_req || i_ddc_req;
  assign req[3] = i_adc_req || i_power_fail_input;

  // Requests of this last cycle compete with those already stored
  assign pend_now = c_q.pend | req;

  // Fixed priority: lowest vector number wins
  generate
    for (genvar g = 0; g < NUM_MASKABLE; g++) begin : g_prio
      if (g == 0) begin : g_first
        assign grant[g] = pend_now[g];
      end else begin : g_rest
        assign grant[g] = pend_now[g] && (pend_now[g-1:0] == '0);
      end
    end
  endgenerate

  always_comb begin
    c_d             = c_q;
    c_d.pc_load     = 1'b0;
    c_d.stack_clear = 1'b0;
    c_d.enter_wait  = 1'b0;
    c_d.wd_rdata    = wd_rdata;
    c_d.core_reset  = seq_reset;
    c_d.ports_input = seq_ports;
    // Requests seen only in last cycle; a vector already holding one drops more
    if (i_core_ev.instr_last) begin
      c_d.pend     = c_q.pend | req;
      c_d.nmi_pend = c_q.nmi_pend | i_nmi_req;
    end
    if (i_data_wr && i_data_addr == IRQ_OPT_ADDR) begin
      c_d.gen = i_data_wdata[GEN_BIT];
    end
    if (i_core_ev.stop_instr) begin
      c_d.enter_wait = 1'b1;
    end
    if (seq_reset) begin
      c_d.pend        = '0;
      c_d.nmi_pend    = 1'b0;
      c_d.nmi_mode    = 1'b1;
      c_d.irq_mode    = 1'b0;
      c_d.gen         = 1'b0;
      c_d.stack_clear = 1'b1;
      c_d.enter_wait  = 1'b0;
    end else if (seq_load_vec) begin
      c_d.pc_load     = 1'b1;
      c_d.pc_value    = RESET_VECTOR;
      c_d.stack_clear = 1'b1;
    end else if (i_core_ev.instr_last) begin
      // Return leaves the current mode before the maskable grant is judged; the NMI grant still sees the old mode
      if (i_core_ev.return_from_irq_instr) begin
        if (c_q.nmi_mode) begin
          c_d.nmi_mode = 1'b0;
        end else begin
          c_d.irq_mode = 1'b0;
        end
      end
      if (c_d.nmi_pend && !c_q.nmi_mode) begin
        c_d.nmi_pend = 1'b0;
        c_d.nmi_mode = 1'b1;
        c_d.pc_load  = 1'b1;
        c_d.pc_value = NMI_VECTOR;
      end else if (!c_d.nmi_mode && !c_d.irq_mode && c_q.gen && pend_now != '0) begin
        c_d.irq_mode = 1'b1;
        c_d.pc_load  = 1'b1;
        c_d.pc_value = VEC1_ADDR;
        for (int i = 0; i < NUM_MASKABLE; i++) begin
          if (grant[i]) begin
            c_d.pc_value = VEC1_ADDR - 12'(i) * VEC_STEP;
            // Served request frees the vector for one new request
            c_d.pend[i]  = 1'b0;
          end
        end
      end
    end
  end

  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      c_q <= '{pend: '0, nmi_pend: 1'b0, nmi_mode: 1'b1, irq_mode: 1'b0, gen: 1'b0,
               pc_load: 1'b0, pc_value: RESET_VECTOR, stack_clear: 1'b1, enter_wait: 1'b0,
               wd_rdata: WD_RESET_VAL, core_reset: 1'b1, ports_input: 1'b1};
    end else begin
      c_q <= c_d;
    end
  end

  assign o_wd_rdata           = c_q.wd_rdata;
  assign o_core_reset         = c_q.core_reset;
  assign o_ports_input_pullup = c_q.ports_input;
  assign o_stack_clear        = c_q.stack_clear;
  assign o_pc_load            = c_q.pc_load;
  assign o_pc_value           = c_q.pc_value;
  assign o_nmi_mode           = c_q.nmi_mode;
  assign o_irq_mode           = c_q.irq_mode;
  assign o_enter_wait         = c_q.enter_wait;

  property p_no_irq_in_nmi;
    @(posedge i_clock) disable iff (i_reset)
      (!seq_reset && c_q.nmi_mode && !(i_core_ev.instr_last && i_core_ev.return_from_irq_instr)) |=> !(o_pc_load && o_irq_mode && !$past(c_q.irq_mode));
  endproperty
  a_no_irq_in_nmi: assert property (p_no_irq_in_nmi) else $error("Maskable taken in NMI mode");

  property p_gen_blocks;
    @(posedge i_clock) disable iff (i_reset)
      (!c_q.gen && !seq_reset) |=> !(o_irq_mode && !$past(c_q.irq_mode));
  endproperty
  a_gen_blocks: assert property (p_gen_blocks) else $error("Maskable taken while disabled");

  property p_prio;
    @(posedge i_clock) disable iff (i_reset)
      (!seq_reset && !seq_load_vec && i_core_ev.instr_last && !c_q.nmi_mode && !c_q.irq_mode
       && !c_q.nmi_pend && !i_nmi_req && c_q.gen && c_q.pend[0]) |=> o_pc_load && o_pc_value == 12'hff6;
  endproperty
  a_prio: assert property (p_prio) else $error("Vector 1 not first");

  property p_reset_state;
    @(posedge i_clock) disable iff (i_reset) seq_reset |=> o_nmi_mode && o_stack_clear && o_core_reset;
  endproperty
  a_reset_state: assert property (p_reset_state) else $error("Reset state wrong");

  property p_sample_only_last;
    @(posedge i_clock) disable iff (i_reset)
      (!seq_reset && !i_core_ev.instr_last) |=> c_q.pend == $past(c_q.pend);
  endproperty
  a_sample_only_last: assert property (p_sample_only_last) else $error("Sampled mid instruction");

  property p_stop_wait;
    @(posedge i_clock) disable iff (i_reset) (i_core_ev.stop_instr && !seq_reset) |=> o_enter_wait;
  endproperty
  a_stop_wait: assert property (p_stop_wait) else $error("Stop not turned into wait");

  property p_ports_follow;
    @(posedge i_clock) disable iff (i_reset)
      o_ports_input_pullup == o_core_reset;
  endproperty
  a_ports_follow: assert property (p_ports_follow) else $error("Port state not tied to reset");

  property p_pc_source;
    @(posedge i_clock) disable iff (i_reset)
      o_pc_load |-> $past(seq_load_vec) || $past(i_core_ev.instr_last);
  endproperty
  a_pc_source: assert property (p_pc_source) else $error("Program counter loaded off cycle");

  property p_nmi_preempt;
    @(posedge i_clock) disable iff (i_reset)
      (!seq_reset && !seq_load_vec && i_core_ev.instr_last && i_nmi_req && !c_q.nmi_mode)
        |=> o_pc_load && o_nmi_mode && o_pc_value == NMI_VECTOR;
  endproperty
  a_nmi_preempt: assert property (p_nmi_preempt) else $error("NMI did not preempt");

  property p_no_nest;
    @(posedge i_clock) disable iff (i_reset)
      (!seq_reset && !seq_load_vec && c_q.irq_mode && !(i_core_ev.instr_last && i_core_ev.return_from_irq_instr))
        |=> !(o_pc_load && o_pc_value != NMI_VECTOR);
  endproperty
  a_no_nest: assert property (p_no_nest) else $error("Maskable request nested");

  property p_return_from_irq_instr_leaves;
    @(posedge i_clock) disable iff (i_reset)
      (!seq_reset && !seq_load_vec && i_core_ev.instr_last && i_core_ev.return_from_irq_instr && c_q.nmi_mode
       && !c_q.nmi_pend && !i_nmi_req) |=> !o_nmi_mode;
  endproperty
  a_return_from_irq_instr_leaves: assert property (p_return_from_irq_instr_leaves) else $error("Return kept NMI mode");

  property p_fall_through;
    @(posedge i_clock) disable iff (i_reset)
      (!seq_reset && !seq_load_vec && i_core_ev.instr_last && i_core_ev.return_from_irq_instr && c_q.nmi_mode
       && !c_q.nmi_pend && !i_nmi_req && pend_now == '0) |=> !o_pc_load;
  endproperty
  a_fall_through: assert property (p_fall_through) else $error("Vector loaded with nothing pending");

  property p_grant_clears;
    @(posedge i_clock) disable iff (i_reset)
      (o_pc_load && o_pc_value == VEC1_ADDR) |-> !c_q.pend[0];
  endproperty
  a_grant_clears: assert property (p_grant_clears) else $error("Served vector still pending");

  property p_gen_write;
    @(posedge i_clock) disable iff (i_reset)
      (!seq_reset && i_data_wr && i_data_addr == IRQ_OPT_ADDR) |=> c_q.gen == $past(i_data_wdata[GEN_BIT]);
  endproperty
  a_gen_write: assert property (p_gen_write) else $error("Global enable not stored");

  property p_wait_cause;
    @(posedge i_clock) disable iff (i_reset)
      o_enter_wait |-> $past(i_core_ev.stop_instr);
  endproperty
  a_wait_cause: assert property (p_wait_cause) else $error("Wait without stop");

  c_nmi: cover property (@(posedge i_clock) disable iff (i_reset) o_pc_load && o_pc_value == NMI_VECTOR);
  c_v4: cover property (@(posedge i_clock) disable iff (i_reset) o_pc_load && o_pc_value == 12'hff0);
  c_wait: cover property (@(posedge i_clock) disable iff (i_reset) o_enter_wait);

endmodule : rwi_ctrl
`default_nettype wire

// File: include/rwi_pkg.sv
// Shared constants and types for the reset, watchdog and interrupt controller.
// Assumes one 10 MHz system clock that stands in for the oscillator.
package rwi_pkg;

  // Reset stretch after the last reset source releases
  localparam int unsigned STRETCH_CYCLES = 2048;
  localparam int unsigned STRETCH_W      = 12;

  // Watchdog prescale: one tick every twelve oscillator cycles
  localparam int unsigned WD_DIV         = 12;
  localparam logic [3:0]  WD_DIV_LAST    = 4'hb;
  // Hidden ticks per visible counter step: 256 ticks of twelve cycles is 3072
  localparam logic [7:0]  WD_SUB_LAST    = 8'hff;
  localparam logic [5:0]  WD_COUNT_INIT  = 6'h3f;

  // Data space addresses
  localparam logic [7:0] WD_ADDR         = 8'hd8;
  localparam logic [7:0] IRQ_OPT_ADDR    = 8'hc8;
  localparam int unsigned GEN_BIT        = 4;
  localparam logic [7:0] WD_RESET_VAL    = 8'hfe;
  localparam int unsigned SOFT_RESET_BIT = 1;
  localparam int unsigned ACTIVE_BIT     = 0;

  // Program addresses
  localparam logic [11:0] RESET_VECTOR   = 12'hffe;
  localparam logic [11:0] NMI_VECTOR     = 12'hffc;
  localparam logic [11:0] VEC1_ADDR      = 12'hff6;
  localparam logic [11:0] VEC_STEP       = 12'h002;

  localparam int unsigned NUM_MASKABLE   = 4;

  typedef enum logic [1:0] {
    RWI_RESET,
    RWI_STRETCH,
    RWI_RUN
  } rwi_phase_t;

  // Reset sequencer state
  typedef struct packed {
    rwi_phase_t             phase;
    logic [STRETCH_W-1:0]   cnt;
    logic                   core_reset;
    logic                   ports_input;
    logic                   load_vector;
  } rwi_seq_t;

  // Watchdog state
  typedef struct packed {
    logic [3:0] div;
    logic [7:0] sub;
    logic [5:0] count;
    logic       soft_reset_bit;
    logic       active;
    logic       expire;
  } rwi_wd_t;

  // Per-cycle handshake from the core
  typedef struct packed {
    logic instr_last;
    logic return_from_irq_instr;
    logic stop_instr;
  } rwi_core_ev_t;

endpackage : rwi_pkg

// File: design/rwi_reset_seq.sv
// Reset stretcher: holds the core in reset until every source is quiet,
// then 2048 further cycles. Asynchronous reset stands for power-on.
`timescale 1ns/100ps
`default_nettype none
module rwi_reset_seq
  import rwi_pkg::*;
(
  input  wire logic i_clock,
  input  wire logic i_reset,
  input  wire logic i_pin_reset_n,
  input  wire logic i_wd_reset,
  output logic      o_core_reset,
  output logic      o_ports_input,
  output logic      o_load_vector
);

  rwi_seq_t s_q;
  rwi_seq_t s_d;
  logic     src;

  always_comb begin
    src  = !i_pin_reset_n || i_wd_reset;
    s_d  = s_q;
    s_d.load_vector = 1'b0;
    case (s_q.phase)
      RWI_RESET: begin
        s_d.cnt = '0;
        if (!src) begin
          s_d.phase = RWI_STRETCH;
        end
      end
      RWI_STRETCH: begin
        if (src) begin
          s_d.phase = RWI_RESET;
        end else if (s_q.cnt == STRETCH_W'(STRETCH_CYCLES - 1)) begin
          s_d.phase       = RWI_RUN;
          s_d.load_vector = 1'b1;
        end else begin
          s_d.cnt = s_q.cnt + 1'b1;
        end
      end
      default: begin
        if (src) begin
          s_d.phase = RWI_RESET;
        end
      end
    endcase
    s_d.core_reset  = (s_d.phase != RWI_RUN);
    s_d.ports_input = (s_d.phase != RWI_RUN);
  end

  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      s_q <= '{phase: RWI_RESET, cnt: '0, core_reset: 1'b1, ports_input: 1'b1, load_vector: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign o_core_reset  = s_q.core_reset;
  assign o_ports_input = s_q.ports_input;
  assign o_load_vector = s_q.load_vector;

  property p_stretch_len;
    @(posedge i_clock) disable iff (i_reset)
      (s_q.phase == RWI_RESET && !src) ##1 (!src)[*8] |-> o_core_reset;
  endproperty
  a_stretch_len: assert property (p_stretch_len) else $error("Reset released early");

  property p_src_resets;
    @(posedge i_clock) disable iff (i_reset) src |=> o_core_reset && o_ports_input;
  endproperty
  a_src_resets: assert property (p_src_resets) else $error("Reset source not obeyed");

  property p_vec_at_release;
    @(posedge i_clock) disable iff (i_reset) $fell(o_core_reset) |-> o_load_vector;
  endproperty
  a_vec_at_release: assert property (p_vec_at_release) else $error("No vector load at release");

  c_release: cover property (@(posedge i_clock) disable iff (i_reset) $fell(o_core_reset));

endmodule : rwi_reset_seq
`default_nettype wire

// File: design/rwi_watchdog.sv
// Always-on watchdog with its data space register.
// Assumes the write strobe is one cycle and reset comes from the sequencer.
`timescale 1ns/100ps
`default_nettype none
module rwi_watchdog
  import rwi_pkg::*;
(
  input  wire logic       i_clock,
  input  wire logic       i_reset,
  input  wire logic       i_core_reset,
  input  wire logic       i_wr,
  input  wire logic [7:0] i_wdata,
  output logic [7:0]      o_rdata,
  output logic            o_expire
);

  rwi_wd_t w_q;
  rwi_wd_t w_d;
  logic    tick;
  logic [5:0] wr_cnt;

  // Counter bits reversed in the register image
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      o_rdata[7-i] = w_q.count[i];
      wr_cnt[i]    = i_wdata[7-i];
    end
    o_rdata[SOFT_RESET_BIT] = w_q.soft_reset_bit;
    o_rdata[ACTIVE_BIT]     = w_q.active;
  end

  always_comb begin
    w_d        = w_q;
    w_d.expire = 1'b0;
    tick       = (w_q.div == WD_DIV_LAST);
    w_d.div    = tick ? 4'h0 : w_q.div + 4'h1;
    if (i_core_reset) begin
      w_d = '{div: 4'h0, sub: '0, count: WD_COUNT_INIT, soft_reset_bit: 1'b1, active: 1'b0, expire: 1'b0};
    end else if (i_wr) begin
      w_d.count          = wr_cnt;
      w_d.sub            = '0;
      w_d.soft_reset_bit = i_wdata[SOFT_RESET_BIT];
      w_d.expire         = !i_wdata[SOFT_RESET_BIT];
      // Activation bit ignores writes
      w_d.active         = 1'b1;
    end else if (tick) begin
      w_d.sub    = w_q.sub + 8'h01;
      w_d.active = 1'b1;
      // Visible bits step once per 256 ticks, so timeouts span 3072 to 196608 cycles
      if (w_q.sub == WD_SUB_LAST) begin
        w_d.count  = w_q.count - 6'h01;
        w_d.expire = (w_q.count == 6'h00);
      end
    end
  end

  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      w_q <= '{div: 4'h0, sub: '0, count: WD_COUNT_INIT, soft_reset_bit: 1'b1, active: 1'b0, expire: 1'b0};
    end else begin
      w_q <= w_d;
    end
  end

  assign o_expire = w_q.expire;

  property p_wrap_resets;
    @(posedge i_clock) disable iff (i_reset)
      (!i_core_reset && !i_wr && tick && w_q.sub == WD_SUB_LAST && w_q.count == 6'h00) |=> o_expire;
  endproperty
  a_wrap_resets: assert property (p_wrap_resets) else $error("Wrap gave no reset");

  property p_soft_reset;
    @(posedge i_clock) disable iff (i_reset)
      (!i_core_reset && i_wr && !i_wdata[SOFT_RESET_BIT]) |=> o_expire;
  endproperty
  a_soft_reset: assert property (p_soft_reset) else $error("Soft reset lost");

  property p_counting;
    @(posedge i_clock) disable iff (i_reset)
      (!i_core_reset && !i_wr && tick && w_q.sub == WD_SUB_LAST && w_q.count != 6'h00)
        |=> w_q.count == $past(w_q.count) - 6'h01;
  endproperty
  a_counting: assert property (p_counting) else $error("Counter did not step");

  property p_count_hold;
    @(posedge i_clock) disable iff (i_reset)
      (!i_core_reset && !i_wr && !(tick && w_q.sub == WD_SUB_LAST)) |=> w_q.count == $past(w_q.count);
  endproperty
  a_count_hold: assert property (p_count_hold) else $error("Counter stepped between steps");

  c_expire: cover property (@(posedge i_clock) disable iff (i_reset) o_expire);

endmodule : rwi_watchdog
`default_nettype wire

// File: verif/rwi_core_model.sv
// Behavioural model of the core's instruction strobes and the interrupt sources.
// Assumes the bench calls instr only while the core is out of reset.
`timescale 1ns/100ps
`default_nettype none
module rwi_core_model
  import rwi_pkg::*;
(
  input  wire logic        i_clock,
  output var rwi_core_ev_t o_core_ev,
  output var logic [10:0]  o_req
);
  initial begin
    o_core_ev = '0;
    o_req     = '0;
  end

  // Requests stay valid through the last cycle, so a slow gap is safe
  task automatic instr(input logic return_from_irq_instr, input logic stop, input logic [10:0] req, input int gap);
    @(posedge i_clock);
    o_req <= req;
    repeat (gap) @(posedge i_clock);
    o_core_ev <= '{instr_last: 1'b1, return_from_irq_instr: return_from_irq_instr, stop_instr: stop};
    @(posedge i_clock);
    o_core_ev <= '0;
    o_req     <= '0;
  endtask
endmodule // rwi_core_model
`default_nettype wire

// File: verif/rwi_ctrl_tb.sv
// Self-checking bench for the reset, watchdog and interrupt controller.
// Assumes rwi_core_model stands in for the core and the peripheral sources.
`timescale 1ns/100ps
`default_nettype none
module rwi_ctrl_tb
  import rwi_pkg::*;
;
  logic         i_clock;
  logic         i_reset;
  logic         i_pin_reset_n;
  logic         i_data_wr;
  logic [7:0]   i_data_addr;
  logic [7:0]   i_data_wdata;
  rwi_core_ev_t core_ev;
  logic [10:0]  req;
  logic [7:0]   wd_rdata;
  logic [11:0]  pc_value;
  logic         core_reset, ports_pullup, stack_clear, pc_load, nmi_mode, irq_mode, enter_wait;
  int           mismatches, cmp_count, gap, n;

  initial begin
    i_clock = 1'b0;
    forever #50 i_clock = ~i_clock;
  end

  rwi_ctrl i_rwi_ctrl (
    .i_clock(i_clock), .i_reset(i_reset), .i_pin_reset_n(i_pin_reset_n), .i_nmi_req(req[0]),
    .i_timer3_req(req[1]), .i_port_a_req(req[2]), .i_port_b_req(req[3]), .i_timer2_req(req[4]),
    .i_vsync_req(req[5]), .i_i2c_req(req[6]), .i_timer1_req(req[7]), .i_ddc_req(req[8]),
    .i_adc_req(req[9]), .i_power_fail_input(req[10]), .i_core_ev(core_ev), .i_data_wr(i_data_wr),
    .i_data_addr(i_data_addr), .i_data_wdata(i_data_wdata), .o_wd_rdata(wd_rdata),
    .o_core_reset(core_reset), .o_ports_input_pullup(ports_pullup), .o_stack_clear(stack_clear),
    .o_pc_load(pc_load), .o_pc_value(pc_value), .o_nmi_mode(nmi_mode), .o_irq_mode(irq_mode),
    .o_enter_wait(enter_wait)
  );

  rwi_core_model i_rwi_core_model (.i_clock(i_clock), .o_core_ev(core_ev), .o_req(req));

  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [11:0] got, input logic [11:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clock);
    i_data_wr    <= 1'b1;
    i_data_addr  <= a;
    i_data_wdata <= d;
    @(posedge i_clock);
    i_data_wr <= 1'b0;
  endtask

  // Counts cycles from a reset release until the core runs again
  // Start gives the reset cycles that the caller has already waited
  task automatic stretch(input int start);
    n = start;
    check("ports_pullup", 12'(ports_pullup), 12'h1);
    while (core_reset !== 1'b0) begin
      @(negedge i_clock);
      n++;
      if (n > 2200) begin
        mismatches++;
        end_of_test();
      end
    end
    check("stretch_len", 12'(n >= 2048 && n <= 2054), 12'h1);
    check("reset_pc_load", 12'(pc_load), 12'h1);
    check("reset_pc", pc_value, 12'hffe);
    check("stack_clear", 12'(stack_clear), 12'h1);
    check("nmi_mode", 12'(nmi_mode), 12'h1);
  endtask

  task automatic step(input logic return_from_irq_instr, input logic stop, input logic [10:0] rq, input logic exp_ld,
                      input logic [11:0] exp_pc);
    logic        ld;
    logic        ew;
    logic [11:0] pc;
    ld = 1'b0;
    ew = 1'b0;
    pc = '0;
    i_rwi_core_model.instr(return_from_irq_instr, stop, rq, gap);
    repeat (3) begin
      @(negedge i_clock);
      if (enter_wait === 1'b1) ew = 1'b1;
      if (pc_load === 1'b1 && ld === 1'b0) begin
        ld = 1'b1;
        pc = pc_value;
      end
    end
    check("pc_load", 12'(ld), 12'(exp_ld));
    check("enter_wait", 12'(ew), 12'(stop));
    if (exp_ld) check("pc_value", pc, exp_pc);
  endtask

  task automatic t_power_on();
    check("wd_reset_image", 12'(wd_rdata), 12'h0fe);
    check("core_reset_on", 12'(core_reset), 12'h1);
    i_reset <= 1'b0;
    stretch(0);
    $display("test power_on done");
  endtask

  task automatic t_pin_reset();
    @(posedge i_clock);
    i_pin_reset_n <= 1'b0;
    repeat (5) @(negedge i_clock);
    check("pin_reset_hold", 12'(core_reset), 12'h1);
    @(posedge i_clock);
    i_pin_reset_n <= 1'b1;
    stretch(0);
    $display("test pin_reset done");
  endtask

  task automatic t_irq_order();
    logic [11:0] vec [4] = '{12'hff6, 12'hff4, 12'hff2, 12'hff0};
    gap = 0;
    wr(8'hd8, 8'hfe);
    wr(8'hc8, 8'h10);
    step(1'b0, 1'b0, 11'h322, 1'b0, 12'h0);
    step(1'b1, 1'b0, 11'h0, 1'b1, 12'hff6);
    check("irq_mode_on", 12'(irq_mode), 12'h1);
    gap = 3;
    step(1'b0, 1'b0, 11'h006, 1'b0, 12'h0);
    for (int i = 0; i < 4; i++) step(1'b1, 1'b0, 11'h0, 1'b1, vec[i]);
    step(1'b1, 1'b0, 11'h0, 1'b0, 12'h0);
    check("irq_mode_off", 12'(irq_mode), 12'h0);
    $display("test irq_order done");
  endtask

  task automatic t_nmi_sources();
    gap = 1;
    wr(8'hd8, 8'hfe);
    step(1'b0, 1'b0, 11'h200, 1'b1, 12'hff0);
    step(1'b0, 1'b0, 11'h001, 1'b1, 12'hffc);
    check("nmi_nested", 12'(nmi_mode), 12'h1);
    step(1'b1, 1'b0, 11'h0, 1'b0, 12'h0);
    check("back_to_irq", 12'({nmi_mode, irq_mode}), 12'h1);
    step(1'b1, 1'b0, 11'h0, 1'b0, 12'h0);
    for (int i = 1; i < 11; i++) begin
      gap = i % 3;
      step(1'b0, 1'b0, 11'(1 << i), 1'b1, i < 4 ? 12'hff6 : i < 7 ? 12'hff4 : i < 9 ? 12'hff2 : 12'hff0);
      step(1'b1, 1'b0, 11'h0, 1'b0, 12'h0);
    end
    $display("test nmi_sources done");
  endtask

  task automatic t_gen_stop();
    wr(8'hc8, 8'h00);
    step(1'b0, 1'b0, 11'h400, 1'b0, 12'h0);
    wr(8'hc8, 8'h10);
    step(1'b0, 1'b0, 11'h0, 1'b1, 12'hff0);
    step(1'b1, 1'b0, 11'h0, 1'b0, 12'h0);
    step(1'b0, 1'b1, 11'h0, 1'b0, 12'h0);
    check("stop_no_reset", 12'(core_reset), 12'h0);
    $display("test gen_stop done");
  endtask

  task automatic t_soft_reset();
    wr(8'hd8, 8'hfc);
    n = 0;
    while (core_reset !== 1'b1 && n < 10) begin
      @(negedge i_clock);
      n++;
    end
    check("soft_reset", 12'(core_reset), 12'h1);
    stretch(0);
    $display("test soft_reset done");
  endtask

  task automatic t_watchdog();
    // Count one reloaded each time keeps the wrap out of reach
    repeat (3) begin
      wr(8'hd8, 8'h82);
      repeat (2500) @(negedge i_clock);
      check("wd_reload", 12'(core_reset), 12'h0);
    end
    wr(8'hd8, 8'h82);
    repeat (2) @(posedge i_clock);
    @(negedge i_clock);
    check("wd_image", 12'(wd_rdata), 12'h083);
    n = 0;
    while (core_reset !== 1'b1) begin
      @(negedge i_clock);
      n++;
      if (n > 6300) begin
        mismatches++;
        end_of_test();
      end
    end
    // Count one runs two steps of 3072 cycles
    check("wd_timeout", 12'(n >= 6100 && n <= 6200), 12'h1);
    repeat (10) @(negedge i_clock);
    check("wd_reinit", 12'(wd_rdata), 12'h0fe);
    stretch(10);
    $display("test watchdog done");
  endtask

  initial begin
    i_reset       = 1'b1;
    i_pin_reset_n = 1'b1;
    i_data_wr     = 1'b0;
    i_data_addr   = 8'h00;
    i_data_wdata  = 8'h00;
    mismatches    = 0;
    cmp_count     = 0;
    gap           = 0;
    n             = 0;
    repeat (3) @(posedge i_clock);
    t_power_on();
    t_pin_reset();
    t_irq_order();
    t_nmi_sources();
    t_gen_stop();
    t_soft_reset();
    t_watchdog();
    end_of_test();
  end
endmodule // rwi_ctrl_tb
`default_nettype wire
